//--- core/adc_scan_seq.sv
// scan sequencer with channel/range list, apb register slave
// assumes converter pins are asynchronous to pclk; conv_data and the
// over-range flags are stable while conv_done is high
//
// What this block does
// - list off: step start to stop channel ascending at one fixed range.
// - local list storage of channel/range pairs, repeats and any order allowed.
// - list on: fetch element zero, apply channel and range, sample, then next.
// - after the last list element, wrap back to element zero.
// - keep scanning until acquired samples equal requested count, then stop.
// - over-range input gives saturated full-scale code, not a fault.
// - output coding is offset binary, zero volts gives code 2048.
// - eight single-ended or four differential channels limit valid channel numbers.
// - twelve bits in differential mode, eleven effective bits single-ended.
// - single-ended channels use only the ten volt range.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module adc_scan_seq (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter front end
  output logic [adc_seq_pkg::CHAN_W-1:0] conv_chan,
  output logic [adc_seq_pkg::RANGE_W-1:0] conv_range,
  output logic conv_diff,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [adc_seq_pkg::CODE_W-1:0] conv_data,
  input wire logic conv_over_hi,
  input wire logic conv_over_lo,
  // result stream
  output logic res_valid,
  output logic [adc_seq_pkg::CODE_W-1:0] res_code,
  output logic [adc_seq_pkg::CHAN_W-1:0] res_chan,
  output logic [adc_seq_pkg::RANGE_W-1:0] res_range,
  output logic scan_busy
);
  import adc_seq_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_CONV, S_WAIT} seq_state_e;

  // ==========================================
  // pin synchronisers
  logic done_s1_r, done_s2_r, done_s3_r;
  logic hi_s1_r, hi_s2_r, lo_s1_r, lo_s2_r;
  logic [CODE_W-1:0] data_s1_r, data_s2_r;
  logic done_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      hi_s1_r <= 1'b0;
      hi_s2_r <= 1'b0;
      lo_s1_r <= 1'b0;
      lo_s2_r <= 1'b0;
      data_s1_r <= '0;
      data_s2_r <= '0;
    end else begin
      done_s1_r <= conv_done;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      hi_s1_r <= conv_over_hi;
      hi_s2_r <= hi_s1_r;
      lo_s1_r <= conv_over_lo;
      lo_s2_r <= lo_s1_r;
      data_s1_r <= conv_data;
      data_s2_r <= data_s1_r;
    end
  end

  assign done_rise = done_s2_r & ~done_s3_r;

  // ==========================================
  // apb registers
  logic qen_r, qen_nxt, diff_r, diff_nxt;
  logic [CHAN_W-1:0] start_ch_r, start_ch_nxt, stop_ch_r, stop_ch_nxt;
  logic [RANGE_W-1:0] fix_range_r, fix_range_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic [CNT_W-1:0] req_r, req_nxt;
  logic [IDX_W-1:0] qaddr_r, qaddr_nxt;
  logic done_r, done_nxt, err_r, err_nxt, over_r, over_nxt;
  logic go_r, go_nxt, abort_r, abort_nxt;
  logic wr_acc, rd_acc, mapped, list_wr;
  logic [CHAN_W-1:0] rb_chan;
  logic [RANGE_W-1:0] rb_range;
  // sequencer signals read by the register group
  seq_state_e state_r, state_nxt;
  logic fin_r, fin_nxt, fail_r, fail_nxt, sat_evt_r, sat_evt_nxt;
  logic [CNT_W-1:0] scount_r, scount_nxt;
  logic busy;

  assign busy = (state_r != S_IDLE);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_CFG) | (paddr == ADDR_COUNT) |
                  (paddr == ADDR_STATUS) | (paddr == ADDR_SAMPLES) | (paddr == ADDR_RESULT) |
                  (paddr == ADDR_QADDR) | (paddr == ADDR_QDATA);
  // zero wait states; every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // list edits during a scan are dropped so the running sequence stays intact
  assign list_wr = wr_acc & (paddr == ADDR_QDATA) & ~busy;

  always_comb begin
    qen_nxt = qen_r;
    diff_nxt = diff_r;
    start_ch_nxt = start_ch_r;
    stop_ch_nxt = stop_ch_r;
    fix_range_nxt = fix_range_r;
    len_nxt = len_r;
    req_nxt = req_r;
    qaddr_nxt = qaddr_r;
    go_nxt = 1'b0;
    abort_nxt = 1'b0;
    done_nxt = done_r;
    err_nxt = err_r;
    over_nxt = over_r;
    if (wr_acc) begin
      case (paddr)
        ADDR_CTRL: begin
          abort_nxt = pwdata[CTRL_ABORT_BIT];
          if (!busy) begin
            qen_nxt = pwdata[CTRL_QEN_BIT];
            diff_nxt = pwdata[CTRL_DIFF_BIT];
            go_nxt = pwdata[CTRL_START_BIT];
          end
        end
        ADDR_CFG: begin
          if (!busy) begin
            start_ch_nxt = pwdata[CFG_START_LSB +: CHAN_W];
            stop_ch_nxt = pwdata[CFG_STOP_LSB +: CHAN_W];
            fix_range_nxt = pwdata[CFG_RANGE_LSB +: RANGE_W];
            len_nxt = pwdata[CFG_LEN_LSB +: LEN_W];
          end
        end
        ADDR_COUNT: begin
          if (!busy) begin
            req_nxt = pwdata[CNT_W-1:0];
          end
        end
        ADDR_STATUS: begin
          // write one to clear
          if (pwdata[ST_DONE_BIT]) done_nxt = 1'b0;
          if (pwdata[ST_ERR_BIT]) err_nxt = 1'b0;
          if (pwdata[ST_OVER_BIT]) over_nxt = 1'b0;
        end
        ADDR_QADDR: begin
          qaddr_nxt = pwdata[IDX_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // each list write steps the pointer, so a list loads with one burst
    if (list_wr) begin
      qaddr_nxt = qaddr_r + IDX_W'(1);
    end
    // hardware events win over a clear in the same cycle
    if (fin_r) done_nxt = 1'b1;
    if (fail_r) err_nxt = 1'b1;
    if (sat_evt_r) over_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qen_r <= 1'b0;
      diff_r <= 1'b0;
      start_ch_r <= START_RST;
      stop_ch_r <= STOP_RST;
      fix_range_r <= bipolar_ten_volt_range;
      len_r <= LEN_RST;
      req_r <= COUNT_RST;
      qaddr_r <= '0;
      go_r <= 1'b0;
      abort_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      over_r <= 1'b0;
    end else begin
      qen_r <= qen_nxt;
      diff_r <= diff_nxt;
      start_ch_r <= start_ch_nxt;
      stop_ch_r <= stop_ch_nxt;
      fix_range_r <= fix_range_nxt;
      len_r <= len_nxt;
      req_r <= req_nxt;
      qaddr_r <= qaddr_nxt;
      go_r <= go_nxt;
      abort_r <= abort_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      over_r <= over_nxt;
    end
  end

  always_comb begin
    prdata = '0;
    if (rd_acc) begin
      case (paddr)
        ADDR_CTRL: begin
          prdata[CTRL_QEN_BIT] = qen_r;
          prdata[CTRL_DIFF_BIT] = diff_r;
        end
        ADDR_CFG: begin
          prdata[CFG_START_LSB +: CHAN_W] = start_ch_r;
          prdata[CFG_STOP_LSB +: CHAN_W] = stop_ch_r;
          prdata[CFG_RANGE_LSB +: RANGE_W] = fix_range_r;
          prdata[CFG_LEN_LSB +: LEN_W] = len_r;
        end
        ADDR_COUNT: prdata[CNT_W-1:0] = req_r;
        ADDR_STATUS: begin
          prdata[ST_BUSY_BIT] = busy;
          prdata[ST_DONE_BIT] = done_r;
          prdata[ST_ERR_BIT] = err_r;
          prdata[ST_OVER_BIT] = over_r;
        end
        ADDR_SAMPLES: prdata[CNT_W-1:0] = scount_r;
        ADDR_RESULT: begin
          prdata[RES_CODE_LSB +: CODE_W] = res_code;
          prdata[RES_CHAN_LSB +: CHAN_W] = res_chan;
          prdata[RES_RANGE_LSB +: RANGE_W] = res_range;
        end
        ADDR_QADDR: prdata[IDX_W-1:0] = qaddr_r;
        ADDR_QDATA: begin
          prdata[ENT_CHAN_LSB +: CHAN_W] = rb_chan;
          prdata[ENT_RANGE_LSB +: RANGE_W] = rb_range;
        end
        default: prdata = '0;
      endcase
    end
  end

  // ==========================================
  // channel list and result formatting
  logic [IDX_W-1:0] idx_r, idx_nxt;
  logic [CHAN_W-1:0] q_chan;
  logic [RANGE_W-1:0] q_range;
  logic [CODE_W-1:0] fmt_code;
  logic fmt_sat;

  adc_chan_list #(.DEPTH(LIST_DEPTH), .IW(IDX_W)) u_list (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(list_wr),
    .wr_idx(qaddr_r),
    .wr_chan(pwdata[ENT_CHAN_LSB +: CHAN_W]),
    .wr_range(pwdata[ENT_RANGE_LSB +: RANGE_W]),
    .rd_idx_a(idx_r),
    .chan_a(q_chan),
    .range_a(q_range),
    .rd_idx_b(qaddr_r),
    .chan_b(rb_chan),
    .range_b(rb_range)
  );

  adc_result_format u_fmt (
    .raw_code(data_s2_r),
    .over_hi(hi_s2_r),
    .over_lo(lo_s2_r),
    .diff_mode(conv_diff),
    .code(fmt_code),
    .saturated(fmt_sat)
  );

  // ==========================================
  // sequencer
  logic [CHAN_W-1:0] chan_r, chan_nxt, chan_max, sel_chan;
  logic [RANGE_W-1:0] range_r, range_nxt, sel_range;
  logic [7:0] settle_r, settle_nxt;
  logic start_r, start_nxt, rv_r, rv_nxt;
  logic [CODE_W-1:0] rcode_r, rcode_nxt;
  logic [CHAN_W-1:0] rchan_r, rchan_nxt;
  logic [RANGE_W-1:0] rrange_r, rrange_nxt;
  logic cfg_ok, last_elem;

  assign chan_max = diff_r ? DIFF_CHAN_MAX : SE_CHAN_MAX;
  assign cfg_ok = (req_r != '0) &&
                  (qen_r ? (len_r != '0 && len_r <= LEN_W'(LIST_DEPTH))
                         : (start_ch_r <= stop_ch_r && stop_ch_r <= chan_max));
  assign sel_chan = qen_r ? q_chan : CHAN_W'(idx_r);
  assign sel_range = qen_r ? q_range : fix_range_r;
  assign last_elem = qen_r ? (idx_r == IDX_W'(len_r - LEN_W'(1))) : (CHAN_W'(idx_r) == stop_ch_r);

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    chan_nxt = chan_r;
    range_nxt = range_r;
    settle_nxt = settle_r;
    scount_nxt = scount_r;
    start_nxt = 1'b0;
    rv_nxt = 1'b0;
    rcode_nxt = rcode_r;
    rchan_nxt = rchan_r;
    rrange_nxt = rrange_r;
    fin_nxt = 1'b0;
    fail_nxt = 1'b0;
    sat_evt_nxt = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (go_r) begin
          if (cfg_ok) begin
            idx_nxt = qen_r ? '0 : IDX_W'(start_ch_r);
            scount_nxt = '0;
            state_nxt = S_SETUP;
            settle_nxt = '0;
          end else begin
            fail_nxt = 1'b1;
          end
        end
      end
      S_SETUP: begin
        // channel and range are applied before the conversion is started
        if (sel_chan > chan_max) begin
          fail_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else begin
          chan_nxt = sel_chan;
          range_nxt = diff_r ? sel_range : RANGE_W'(bipolar_ten_volt_range);
          settle_nxt = settle_r + 8'h01;
          if (settle_r == SETTLE_CYC) begin
            state_nxt = S_CONV;
          end
        end
      end
      S_CONV: begin
        // wait for the previous done to drop so an old level is not taken
        if (!done_s2_r) begin
          start_nxt = 1'b1;
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (done_rise) begin
          rv_nxt = 1'b1;
          rcode_nxt = fmt_code;
          rchan_nxt = chan_r;
          rrange_nxt = range_r;
          sat_evt_nxt = fmt_sat;
          scount_nxt = scount_r + CNT_W'(1);
          settle_nxt = '0;
          if (scount_r + CNT_W'(1) == req_r) begin
            fin_nxt = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            state_nxt = S_SETUP;
            if (last_elem) begin
              idx_nxt = qen_r ? '0 : IDX_W'(start_ch_r);
            end else begin
              idx_nxt = idx_r + IDX_W'(1);
            end
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // abort drops the scan at once; a conversion in flight is discarded
    if (abort_r) begin
      state_nxt = S_IDLE;
      start_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      idx_r <= '0;
      chan_r <= '0;
      range_r <= bipolar_ten_volt_range;
      settle_r <= '0;
      scount_r <= '0;
      start_r <= 1'b0;
      rv_r <= 1'b0;
      rcode_r <= CODE_MID;
      rchan_r <= '0;
      rrange_r <= bipolar_ten_volt_range;
      fin_r <= 1'b0;
      fail_r <= 1'b0;
      sat_evt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      chan_r <= chan_nxt;
      range_r <= range_nxt;
      settle_r <= settle_nxt;
      scount_r <= scount_nxt;
      start_r <= start_nxt;
      rv_r <= rv_nxt;
      rcode_r <= rcode_nxt;
      rchan_r <= rchan_nxt;
      rrange_r <= rrange_nxt;
      fin_r <= fin_nxt;
      fail_r <= fail_nxt;
      sat_evt_r <= sat_evt_nxt;
    end
  end

  assign conv_chan = chan_r;
  assign conv_range = range_r;
  assign conv_diff = diff_r;
  assign conv_start = start_r;
  assign res_valid = rv_r;
  assign res_code = rcode_r;
  assign res_chan = rchan_r;
  assign res_range = rrange_r;
  assign scan_busy = busy;

endmodule : adc_scan_seq

//--- core/adc_seq_pkg.sv
// shared constants for the scan / channel-list sequencer
// assumes a single pclk domain and an apb register slave with 32-bit data
package adc_seq_pkg;

  // ==========================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // mux and gain settling time before each conversion
  localparam int unsigned SETTLE_NS = 1000;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // ==========================================
  // widths
  localparam int CHAN_W = 3;
  localparam int RANGE_W = 3;
  localparam int CODE_W = 12;
  localparam int CNT_W = 16;
  localparam int LEN_W = 5;
  localparam int LIST_DEPTH = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 12;

  // ==========================================
  // input ranges, in selection-code order
  typedef enum logic [RANGE_W-1:0] {
    bipolar_twenty_volt_range,
    bipolar_ten_volt_range,
    bipolar_five_volt_range,
    bipolar_four_volt_range,
    bipolar_two_half_volt_range,
    bipolar_two_volt_range,
    bipolar_one_quarter_volt_range,
    bipolar_one_volt_range
  } range_e;

  // ==========================================
  // channel limits and result codes
  localparam logic [CHAN_W-1:0] SE_CHAN_MAX = 3'h7;
  localparam logic [CHAN_W-1:0] DIFF_CHAN_MAX = 3'h3;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] CODE_FULL = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_W-1:0] SE_LSB_MASK = 12'hffe;

  // ==========================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLES = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_QADDR = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_QDATA = 12'h01c;

  // ==========================================
  // field positions
  localparam int CTRL_QEN_BIT = 0;
  localparam int CTRL_DIFF_BIT = 1;
  localparam int CTRL_START_BIT = 2;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int CFG_START_LSB = 0;
  localparam int CFG_STOP_LSB = 4;
  localparam int CFG_RANGE_LSB = 8;
  localparam int CFG_LEN_LSB = 12;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_OVER_BIT = 3;
  localparam int ENT_CHAN_LSB = 0;
  localparam int ENT_RANGE_LSB = 4;
  localparam int RES_CODE_LSB = 0;
  localparam int RES_CHAN_LSB = 16;
  localparam int RES_RANGE_LSB = 20;

  // ==========================================
  // reset values
  localparam logic [CHAN_W-1:0] START_RST = 3'h0;
  localparam logic [CHAN_W-1:0] STOP_RST = 3'h0;
  localparam logic [LEN_W-1:0] LEN_RST = 5'h01;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0001;

endpackage : adc_seq_pkg

//--- core/adc_chan_list.sv
// channel list storage: one channel / range pair per entry, flip-flops
// assumes one writer port and two independent combinational read ports
`timescale 1ns/1ps
module adc_chan_list #(
  parameter int DEPTH = adc_seq_pkg::LIST_DEPTH,
  parameter int IW = adc_seq_pkg::IDX_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [IW-1:0] wr_idx,
  input wire logic [adc_seq_pkg::CHAN_W-1:0] wr_chan,
  input wire logic [adc_seq_pkg::RANGE_W-1:0] wr_range,
  // read port a (sequencer)
  input wire logic [IW-1:0] rd_idx_a,
  output logic [adc_seq_pkg::CHAN_W-1:0] chan_a,
  output logic [adc_seq_pkg::RANGE_W-1:0] range_a,
  // read port b (register readback)
  input wire logic [IW-1:0] rd_idx_b,
  output logic [adc_seq_pkg::CHAN_W-1:0] chan_b,
  output logic [adc_seq_pkg::RANGE_W-1:0] range_b
);
  import adc_seq_pkg::*;

  logic [CHAN_W-1:0] chan_r [DEPTH];
  logic [RANGE_W-1:0] range_r [DEPTH];

  // ==========================================
  // entries: channels may repeat and sit in any order
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic [CHAN_W-1:0] chan_nxt;
    logic [RANGE_W-1:0] range_nxt;
    always_comb begin
      chan_nxt = chan_r[i];
      range_nxt = range_r[i];
      if (wr_en && wr_idx == IW'(i)) begin
        chan_nxt = wr_chan;
        range_nxt = wr_range;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_r[i] <= '0;
        range_r[i] <= bipolar_ten_volt_range;
      end else begin
        chan_r[i] <= chan_nxt;
        range_r[i] <= range_nxt;
      end
    end
  end

  assign chan_a = chan_r[rd_idx_a];
  assign range_a = range_r[rd_idx_a];
  assign chan_b = chan_r[rd_idx_b];
  assign range_b = range_r[rd_idx_b];

endmodule : adc_chan_list

//--- core/adc_result_format.sv
// turns the converter's signed code into the offset-binary result
// assumes the over-range flags arrive with the code they belong to
`timescale 1ns/1ps
module adc_result_format (
  // converter side
  input wire logic [adc_seq_pkg::CODE_W-1:0] raw_code,
  input wire logic over_hi,
  input wire logic over_lo,
  input wire logic diff_mode,
  // result
  output logic [adc_seq_pkg::CODE_W-1:0] code,
  output logic saturated
);
  import adc_seq_pkg::*;

  logic [CODE_W-1:0] biased;

  // ==========================================
  // two's complement plus mid-scale is offset binary; 0 v lands on 2048
  assign biased = raw_code ^ CODE_MID;

  always_comb begin
    saturated = over_hi | over_lo;
    if (over_hi) begin
      code = CODE_FULL;
    end else if (over_lo) begin
      code = CODE_ZERO;
    end else if (diff_mode) begin
      code = biased;
    end else begin
      // single-ended only has eleven effective bits
      code = biased & SE_LSB_MASK;
    end
  end

endmodule : adc_result_format

//--- bench/adc_scan_seq_checker.sv
// concurrent checks on the sequencer's converter and result ports
// assumes it is bound into adc_scan_seq, one pclk domain
`timescale 1ns/1ps
module adc_scan_seq_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // converter
  input wire logic [2:0] conv_chan,
  input wire logic [2:0] conv_range,
  input wire logic conv_diff,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  input wire logic conv_over_hi,
  input wire logic conv_over_lo,
  // results
  input wire logic res_valid,
  input wire logic [11:0] res_code,
  input wire logic scan_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // converter control
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  // the channel at the start must equal its value 100 cycles before
  chk_mux_settled: assert property (conv_start |-> conv_chan == $past(conv_chan, 100))
    else $error("channel moved during settling");
  chk_se_range: assert property (conv_start && !conv_diff |-> conv_range == 3'h1)
    else $error("single-ended range not ten volts");
  chk_diff_chan: assert property (conv_start && conv_diff |-> conv_chan <= 3'h3)
    else $error("differential channel out of range");
  chk_idle_quiet: assert property (!scan_busy |-> !conv_start)
    else $error("conversion started while idle");
  // ==========================================
  // result coding
  chk_se_lsb: assert property (res_valid && !conv_diff |-> !res_code[0])
    else $error("single-ended result has lsb set");
  chk_over_full: assert property ($rose(conv_done) && conv_over_hi && conv_diff |-> ##3 res_valid && res_code == 12'hfff)
    else $error("over-range not full scale");
  chk_code_map: assert property ($rose(conv_done) && !conv_over_hi && !conv_over_lo |-> ##3 res_valid
    && res_code == (($past(conv_data, 3) ^ 12'h800) & {11'h7ff, conv_diff}))
    else $error("result not offset binary");
endmodule : adc_scan_seq_checker

bind adc_scan_seq adc_scan_seq_checker chk_i (.pclk, .presetn, .conv_chan, .conv_range, .conv_diff,
  .conv_start, .conv_done, .conv_data, .conv_over_hi, .conv_over_lo, .res_valid, .res_code, .scan_busy);

//--- bench/adc_front_end_model.sv
// behavioural converter facing the sequencer
// assumes conv_start is a one-cycle pulse; lag sets prompt or slow answers
`timescale 1ns/1ps
module adc_front_end_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  input wire logic conv_start,
  output logic conv_done = 1'b0,
  output logic [11:0] conv_data = 12'h000,
  output logic conv_over_hi = 1'b0,
  output logic conv_over_lo = 1'b0,
  // bench control
  input wire logic [7:0] lag,
  input wire logic [11:0] code_in,
  input wire logic hi_in
);
  logic [7:0] cnt;
  logic run;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      cnt <= '0;
      conv_done <= 1'b0;
    end else begin
      // outside the done window the lines keep changing, so stale data never looks valid
      if (!conv_done) begin
        conv_data <= ~conv_data;
        conv_over_hi <= ~conv_over_hi;
        conv_over_lo <= ~conv_over_lo;
      end
      if (conv_start) begin
        run <= 1'b1;
        cnt <= lag;
      end else if (cnt != '0) begin
        cnt <= cnt - 8'h01;
      end else if (run && !conv_done) begin
        conv_done <= 1'b1;
        conv_data <= code_in;
        conv_over_hi <= hi_in;
        conv_over_lo <= 1'b0;
        cnt <= 8'h06;
      end else begin
        conv_done <= 1'b0;
        run <= 1'b0;
      end
    end
  end
endmodule : adc_front_end_model

//--- bench/adc_scan_gain_queue_sequencer_bench.sv
// register-level bench for the scan sequencer over apb
// assumes the front-end model answers every conversion start
`timescale 1ns/1ps
module adc_scan_gain_queue_sequencer_bench;
  import adc_seq_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic hi_in = 1'b0;
  logic [11:0] paddr = '0;
  logic [11:0] code_in = '0;
  logic [31:0] pwdata = '0;
  logic [7:0] lag = 8'h02;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, conv_start, conv_done, conv_diff, conv_over_hi, conv_over_lo, res_valid, scan_busy;
  logic [2:0] conv_chan, conv_range, res_chan, res_range;
  logic [11:0] conv_data, res_code;
  logic [17:0] q[$];
  logic [7:0] ent[4] = '{8'h10, 8'h20, 8'h13, 8'h72};
  int n_mismatch = 0;
  int samples_checked = 0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) if (res_valid === 1'b1) q.push_back({res_chan, res_range, res_code});
  adc_scan_seq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conv_chan, .conv_range, .conv_diff, .conv_start, .conv_done, .conv_data, .conv_over_hi, .conv_over_lo,
    .res_valid, .res_code, .res_chan, .res_range, .scan_busy);
  adc_front_end_model fe (.pclk, .presetn, .conv_start, .conv_done, .conv_data, .conv_over_hi,
    .conv_over_lo, .lag, .code_in, .hi_in);
  // ==========================================
  // tasks
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(r, exp);
  endtask : rc
  // scans are long; wait on the busy port, then let the last result land
  task automatic run_scan(input logic [31:0] ctrl);
    int k;
    k = 0;
    apb(1'b1, ADDR_STATUS, 32'hf);
    q.delete();
    apb(1'b1, ADDR_CTRL, ctrl);
    repeat (3) @(posedge pclk);
    while (scan_busy !== 1'b0 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    repeat (6) @(posedge pclk);
    if (k >= 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask : run_scan
  // ==========================================
  // scenarios
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rc(ADDR_CFG, 32'h1100);
    rc(ADDR_COUNT, 32'h1);
    rc(ADDR_STATUS, 32'h0);
    rc(12'h020, 32'h0);
    chk(e, 32'h1);
    // plain single-ended, range 5 asked for but ten volts applied
    code_in <= 12'h123;
    apb(1'b1, ADDR_CFG, 32'h1542);
    apb(1'b1, ADDR_COUNT, 32'h5);
    run_scan(32'h4);
    apb(1'b1, ADDR_CFG, 32'h0);
    rc(ADDR_CFG, 32'h0);
    chk(q.size(), 32'h5);
    for (int i = 0; i < 5; i++) chk(q[i], {3'(2 + i % 3), 3'h1, 12'h922});
    rc(ADDR_SAMPLES, 32'h5);
    // list mode, differential, slow converter, wraps after four entries
    lag <= 8'h28;
    code_in <= 12'h000;
    apb(1'b1, ADDR_QADDR, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, ADDR_QDATA, {24'h0, ent[i]});
    apb(1'b1, ADDR_QADDR, 32'h2);
    rc(ADDR_QDATA, 32'h13);
    apb(1'b1, ADDR_CFG, 32'h4000);
    apb(1'b1, ADDR_COUNT, 32'h6);
    run_scan(32'h7);
    chk(q.size(), 32'h6);
    for (int i = 0; i < 6; i++) chk(q[i], {ent[i % 4][2:0], ent[i % 4][6:4], 12'h800});
    // over-range input saturates without a fault
    hi_in <= 1'b1;
    apb(1'b1, ADDR_CFG, 32'h1211);
    apb(1'b1, ADDR_COUNT, 32'h1);
    run_scan(32'h6);
    rc(ADDR_RESULT, 32'h0021_0fff);
    rc(ADDR_STATUS, 32'ha);
    // channel 5 is not a differential channel
    hi_in <= 1'b0;
    apb(1'b1, ADDR_CFG, 32'h1255);
    run_scan(32'h6);
    chk(q.size(), 32'h0);
    rc(ADDR_STATUS, 32'h4);
    // abort ends a running scan at once, without done; err stays sticky
    apb(1'b1, ADDR_CFG, 32'h1011);
    apb(1'b1, ADDR_CTRL, 32'h6);
    apb(1'b1, ADDR_CTRL, 32'h8);
    rc(ADDR_STATUS, 32'h4);
    chk(q.size(), 32'h0);
    report_and_stop;
  end
endmodule : adc_scan_gain_queue_sequencer_bench
